// ==== logic/flash_prog_defs.svh ====
/*
 Offsets, field positions, reset values, key words and operation codes
 for the flash program/erase control block.
 Assumes byte addresses on the peripheral bus, one 32-bit word per
 register, aliases in address bits 3:2 of the control and address groups.
*/
`ifndef FLASH_PROG_DEFS_SVH
`define FLASH_PROG_DEFS_SVH

// Register group bases (byte addresses)
`define CTRL_OFS          8'h00
`define KEY_OFS           8'h10
`define ADDR_OFS          8'h20
`define DATA_OFS          8'h30

// Alias selectors taken from address bits 3:2
`define ALIAS_PLAIN       2'h0
`define ALIAS_CLR         2'h1
`define ALIAS_SET         2'h2
`define ALIAS_INV         2'h3

// Control register fields
`define START_BIT         15
`define PEN_BIT           14
`define FAIL_BIT          13
`define LVF_BIT           12
`define LVL_BIT           11
`define OP_MSB            3

// Reset values and valid-bit masks
`define CTRL_RESET        32'h0000_0000
`define ADDR_RESET        32'h0000_0000
`define DATA_RESET        32'h0000_0000
`define ADDR_VALID        32'hFFFF_FFFC

// Unlock key words, in order
`define KEY_FIRST         32'hAA99_6655
`define KEY_SECOND        32'h5566_99AA

// Operation codes
`define OP_NONE           4'h0
`define OP_WORD           4'h1
`define OP_ROW            4'h3
`define OP_PAGE           4'h4
`define OP_ARRAY          4'h5

`endif

// ==== logic/flash_prog_pkg.sv ====
/*
 Types shared by the flash program/erase control block.
 Assumes the constants header is included by users where needed.
*/
package flash_prog_pkg;

	typedef enum logic [1:0] {
		UNLOCK_IDLE,
		UNLOCK_HALF,
		UNLOCK_OPEN
	} unlock_e;

	typedef enum logic {
		SEQ_IDLE,
		SEQ_BUSY
	} seq_e;

	typedef struct packed {
		logic [3:0]  op;
		logic [31:0] addr;
	} cmd_s;

endpackage

// ==== logic/flash_prog_erase_control.sv ====
/*
 Program/erase control front end: control, unlock key, target address
 and data registers on a simple peripheral register port, unlock
 tracker, operation launch toward the flash array macro, error flags
 and low-voltage detector handling.
 Assumes a single-cycle register port on clk_i, a flash macro that
 answers each start with one done pulse, and an asynchronous
 low-voltage detector output.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_defs.svh"

// Functional notes
// - Start bit accepted only with program enable set, right after unlock.
// - Start launches the selected operation; hardware clears it on finish.
// - Program enable gates start writes and switches the detector on.
// - Device reset clears program enable only; other control bits survive.
// - Failure flag set when an operation fails, zero after normal finish.
// - Low-voltage error flag set on low supply during an operation.
// - Low-voltage status bit follows the enabled detector live.
// - Starting operation code zero clears the three status flags.
// - Operation select is writable only while program enable is zero.
// - Code 0001 programs one word, 0011 programs one row.
// - Code 0100 erases a page, 0101 erases the whole main array.
// - Protected targets are skipped; array erase needs no page protected.
// - Unlock key register is write-only and reads as zero.
// - Target address names word, row or page; ignored for array erase.
// - Clear alias at +0x4 clears bits written as one.
// - Set alias at +0x8 sets bits written as one.
// - Invert alias at +0xC toggles bits written as one.
// - Two key words in order; only the next transaction may set the start bit.
// - Flash data register is cleared by power-on reset only.
module flash_prog_erase_control
	import flash_prog_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and resets
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic              dev_reset_i,
	// Register port
	input  wire logic              bus_valid_i,
	input  wire logic              bus_write_i,
	input  wire logic [ADDR_W-1:0] bus_addr_i,
	input  wire logic [31:0]       bus_wdata_i,
	output logic      [31:0]       bus_rdata_o,
	// Flash array macro
	output cmd_s                   flash_cmd_o,
	output logic                   flash_start_o,
	output logic      [31:0]       flash_data_o,
	input  wire logic              flash_done_i,
	input  wire logic              flash_fail_i,
	input  wire logic              target_protected_i,
	input  wire logic              array_protected_i,
	// Low-voltage detector
	input  wire logic              lvd_raw_i,
	output logic                   lvd_enable_o
);

	function automatic logic [31:0] apply_alias(
		input logic [31:0] cur,
		input logic [31:0] wd,
		input logic [1:0]  kind
	);
		logic [31:0] res;
		res = wd;
		unique case (kind)
			`ALIAS_PLAIN: res = wd;
			`ALIAS_CLR:   res = cur & ~wd;
			`ALIAS_SET:   res = cur | wd;
			`ALIAS_INV:   res = cur ^ wd;
		endcase
		return res;
	endfunction

	// Power-on values of the control fields
	localparam logic [31:0] CTRL_INIT = `CTRL_RESET;

	// Register state
	logic        start_reg;
	logic        pen_reg;
	logic        fail_reg;
	logic        lvf_reg;
	logic        lvl_reg;
	logic [3:0]  op_reg;
	logic [31:0] addr_reg;
	logic [31:0] data_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        lvd_meta_reg;
	logic        lvd_sync_reg;
	logic        flash_start_reg;
	cmd_s        cmd_reg;
	unlock_e     unlock_reg;
	unlock_e     unlock_next;
	seq_e        seq_reg;

	// Address decode
	wire [ADDR_W-1:0] group_base = {bus_addr_i[ADDR_W-1:4], 4'h0};
	wire [1:0]        alias_sel  = bus_addr_i[3:2];
	wire              is_plain   = (alias_sel == `ALIAS_PLAIN);
	wire              wr_req     = bus_valid_i & bus_write_i;
	wire              rd_req     = bus_valid_i & ~bus_write_i;

	wire ctrl_sel = (group_base == ADDR_W'(`CTRL_OFS));
	wire addr_sel = (group_base == ADDR_W'(`ADDR_OFS));
	wire key_sel  = (bus_addr_i == ADDR_W'(`KEY_OFS));
	wire data_sel = (bus_addr_i == ADDR_W'(`DATA_OFS));

	wire ctrl_wr = wr_req & ctrl_sel;
	wire addr_wr = wr_req & addr_sel;
	wire key_wr  = wr_req & key_sel;
	wire data_wr = wr_req & data_sel;

	// Control word as software sees it
	wire [31:0] ctrl_cur = {16'h0000, start_reg, pen_reg, fail_reg,
		lvf_reg, lvl_reg, 7'h00, op_reg};
	wire [31:0] ctrl_new = apply_alias(ctrl_cur, bus_wdata_i, alias_sel);
	wire [31:0] addr_new = apply_alias(addr_reg, bus_wdata_i, alias_sel)
		& `ADDR_VALID;

	// Unlock tracker; the open state lasts one transaction only
	wire unlocked = (unlock_reg == UNLOCK_OPEN);

	always_comb begin
		unlock_next = unlock_reg;
		if (bus_valid_i) begin
			// A first key word restarts the pair from any state
			if (key_wr && bus_wdata_i == `KEY_FIRST) begin
				unlock_next = UNLOCK_HALF;
			end else if (key_wr && unlock_reg == UNLOCK_HALF
				&& bus_wdata_i == `KEY_SECOND) begin
				unlock_next = UNLOCK_OPEN;
			end else begin
				unlock_next = UNLOCK_IDLE;
			end
		end
	end

	// Launch and operation decode
	wire seq_idle = (seq_reg == SEQ_IDLE);
	wire launch   = ctrl_wr & ctrl_new[`START_BIT] & ~start_reg
		& pen_reg & unlocked & seq_idle;
	wire op_real  = (op_reg == `OP_WORD) | (op_reg == `OP_ROW)
		| (op_reg == `OP_PAGE) | (op_reg == `OP_ARRAY);
	wire op_skip  = (op_reg == `OP_ARRAY) ? array_protected_i
		: target_protected_i;
	wire go_flash    = launch & op_real & ~op_skip;
	wire clear_flags = launch & (op_reg == `OP_NONE);
	// A stray done while idle must not touch the flags
	wire op_done     = ~seq_idle & flash_done_i;
	// Detector output is meaningless while it is switched off
	wire lvd_hit     = pen_reg & lvd_sync_reg;

	// Read data
	always_comb begin
		rdata_next = 32'h0000_0000;
		// Key, alias and unmapped reads fall through to zero
		if (rd_req && is_plain) begin
			if (ctrl_sel) begin
				rdata_next = ctrl_cur;
			end else if (addr_sel) begin
				rdata_next = addr_reg;
			end else if (data_sel) begin
				rdata_next = data_reg;
			end
		end
	end

	// Detector synchroniser
	// Only the second stage feeds logic; the first may be metastable
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lvd_meta_reg <= 1'b0;
			lvd_sync_reg <= 1'b0;
		end else begin
			lvd_meta_reg <= lvd_raw_i;
			lvd_sync_reg <= lvd_meta_reg;
		end
	end

	// Unlock state and read data
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			unlock_reg <= UNLOCK_IDLE;
			rdata_reg  <= 32'h0000_0000;
		end else begin
			unlock_reg <= unlock_next;
			rdata_reg  <= rdata_next;
		end
	end

	// Program enable: the only bit a device reset touches
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pen_reg <= CTRL_INIT[`PEN_BIT];
		end else if (dev_reset_i) begin
			pen_reg <= 1'b0;
		end else if (ctrl_wr) begin
			pen_reg <= ctrl_new[`PEN_BIT];
		end
	end

	// Operation select, frozen while enabled so a launch sees a stable code
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			op_reg <= CTRL_INIT[`OP_MSB:0];
		end else if (ctrl_wr && !pen_reg) begin
			op_reg <= ctrl_new[`OP_MSB:0];
		end
	end

	// Start bit and sequencer
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			start_reg <= CTRL_INIT[`START_BIT];
			seq_reg   <= SEQ_IDLE;
		end else if (go_flash) begin
			start_reg <= 1'b1;
			seq_reg   <= SEQ_BUSY;
		end else if (op_done) begin
			start_reg <= 1'b0;
			seq_reg   <= SEQ_IDLE;
		end
	end

	// Failure flag
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fail_reg <= CTRL_INIT[`FAIL_BIT];
		end else if (op_done) begin
			fail_reg <= flash_fail_i;
		end else if (clear_flags) begin
			fail_reg <= 1'b0;
		end
	end

	// Low-voltage error, sticky; a hit wins over a clear
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lvf_reg <= CTRL_INIT[`LVF_BIT];
		end else if (lvd_hit && !seq_idle) begin
			lvf_reg <= 1'b1;
		end else if (clear_flags) begin
			lvf_reg <= 1'b0;
		end
	end

	// Low-voltage status follows the detector
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lvl_reg <= CTRL_INIT[`LVL_BIT];
		end else begin
			lvl_reg <= lvd_hit & ~clear_flags;
		end
	end

	// Target address with aliases
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			addr_reg <= `ADDR_RESET;
		end else if (addr_wr) begin
			addr_reg <= addr_new;
		end
	end

	// Data register; the device reset is deliberately not wired here
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			data_reg <= `DATA_RESET;
		end else if (data_wr) begin
			data_reg <= bus_wdata_i;
		end
	end

	// Command toward the array, held for the whole operation
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cmd_reg         <= '0;
			flash_start_reg <= 1'b0;
		end else begin
			// One-cycle pulse; the command word holds until the next launch
			flash_start_reg <= go_flash;
			if (go_flash) begin
				cmd_reg.op   <= op_reg;
				cmd_reg.addr <= addr_reg;
			end
		end
	end

	assign bus_rdata_o   = rdata_reg;
	assign flash_cmd_o   = cmd_reg;
	assign flash_start_o = flash_start_reg;
	assign flash_data_o  = data_reg;
	assign lvd_enable_o  = pen_reg;

endmodule

`default_nettype wire

// ==== verif/flash_prog_erase_control_props.sv ====
/*
 Concurrent checks for the flash program/erase control block.
 Assumes it is bound to the block's top module and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_defs.svh"
module flash_prog_erase_control_props
	import flash_prog_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic              clk_i,
	input wire logic              reset_i,
	// Register port
	input wire logic              bus_valid_i,
	input wire logic              bus_write_i,
	input wire logic [ADDR_W-1:0] bus_addr_i,
	input wire logic [31:0]       bus_wdata_i,
	input wire logic [31:0]       bus_rdata_o,
	// Flash side
	input wire cmd_s              flash_cmd_o,
	input wire logic              flash_start_o,
	input wire logic [31:0]       flash_data_o
);
	logic      half_reg;
	logic      open_reg;
	wire logic wr = bus_valid_i && bus_write_i;
	wire logic rd = bus_valid_i && !bus_write_i;
	wire logic k1 = wr && bus_addr_i == `KEY_OFS &&
		bus_wdata_i == `KEY_FIRST;
	wire logic k2 = wr && bus_addr_i == `KEY_OFS &&
		bus_wdata_i == `KEY_SECOND;
	wire logic cw = wr && bus_addr_i[ADDR_W-1:4] == '0 &&
		bus_addr_i[3:2] != `ALIAS_CLR;
	wire logic go = open_reg && cw && bus_wdata_i[`START_BIT];
	wire logic dw = wr && bus_addr_i == `DATA_OFS;
	// Own copy of the unlock window; any transaction moves it
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			half_reg <= 1'h0;
			open_reg <= 1'h0;
		end else if (bus_valid_i) begin
			half_reg <= k1;
			open_reg <= k2 && half_reg;
		end
	end
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	sequence s_pair;
		k1 ##1 k2;
	endsequence
	property p_gate; flash_start_o |-> $past(go); endproperty
	a_gate: assert property (p_gate) else $error("launch without unlock");
	property p_pulse; flash_start_o |=> !flash_start_o; endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	property p_window; s_pair ##1 (bus_valid_i && !cw) |=> !flash_start_o[*3];
	endproperty
	a_window: assert property (p_window) else $error("window not closed");
	property p_cmd; !flash_start_o |-> $stable(flash_cmd_o); endproperty
	a_cmd: assert property (p_cmd) else $error("command moved");
	property p_key; rd && bus_addr_i == `KEY_OFS |=> bus_rdata_o == 32'h0;
	endproperty
	a_key: assert property (p_key) else $error("key read not zero");
	property p_alias;
		rd && bus_addr_i[3:2] != `ALIAS_PLAIN |=> bus_rdata_o == 32'h0;
	endproperty
	a_alias: assert property (p_alias) else $error("alias read not zero");
	property p_dwr; dw |=> flash_data_o == $past(bus_wdata_i); endproperty
	a_dwr: assert property (p_dwr) else $error("data not written");
	property p_dhold; !dw |=> $stable(flash_data_o); endproperty
	a_dhold: assert property (p_dhold) else $error("data changed");
endmodule
`default_nettype wire

// ==== verif/flash_prog_erase_control_tb.sv ====
/*
 Self-checking bench for the flash program/erase control block.
 Assumes package, header and checker are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_defs.svh"
module flash_prog_erase_control_tb;
	import flash_prog_pkg::*;
	logic        clk_i = 1'h0;
	logic        reset_i = 1'h1;
	logic        dev_reset_i = 1'h0;
	logic        bus_valid_i = 1'h0;
	logic        bus_write_i = 1'h0;
	logic [7:0]  bus_addr_i = 8'h0;
	logic [31:0] bus_wdata_i = 32'h0;
	logic [31:0] bus_rdata_o;
	cmd_s        flash_cmd_o;
	logic        flash_start_o;
	logic [31:0] flash_data_o;
	logic        flash_done_i = 1'h0;
	logic        flash_fail_i = 1'h0;
	logic        target_protected_i = 1'h0;
	logic        array_protected_i = 1'h0;
	logic        lvd_raw_i = 1'h0;
	logic        lvd_enable_o;
	int          n_mismatch = 0;
	int          comparisons = 0;
	logic        ef = 1'h0;
	logic        el = 1'h0;
	always #5 clk_i = ~clk_i;
	flash_prog_erase_control u_flash_prog_erase_control (
		.clk_i              (clk_i),
		.reset_i            (reset_i),
		.dev_reset_i        (dev_reset_i),
		.bus_valid_i        (bus_valid_i),
		.bus_write_i        (bus_write_i),
		.bus_addr_i         (bus_addr_i),
		.bus_wdata_i        (bus_wdata_i),
		.bus_rdata_o        (bus_rdata_o),
		.flash_cmd_o        (flash_cmd_o),
		.flash_start_o      (flash_start_o),
		.flash_data_o       (flash_data_o),
		.flash_done_i       (flash_done_i),
		.flash_fail_i       (flash_fail_i),
		.target_protected_i (target_protected_i),
		.array_protected_i  (array_protected_i),
		.lvd_raw_i          (lvd_raw_i),
		.lvd_enable_o       (lvd_enable_o)
	);
	task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Leaves the request up so back-to-back calls never double-drive
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		bus_valid_i = 1'h1;
		bus_write_i = w;
		bus_addr_i = a;
		bus_wdata_i = d;
		@(negedge clk_i);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xf(1'h0, a, 32'h0);
		chk("rdata", e, bus_rdata_o);
	endtask
	task automatic idle(input int n);
		bus_valid_i = 1'h0;
		repeat (n) @(negedge clk_i);
	endtask
	task automatic final_report;
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_regs;
		rdc(`CTRL_OFS, `CTRL_RESET);
		rdc(`ADDR_OFS, `ADDR_RESET);
		xf(1'h1, `KEY_OFS, `KEY_FIRST);
		rdc(`KEY_OFS, 32'h0);
		xf(1'h1, 8'h40, 32'hFFFF_FFFF);
		rdc(8'h40, 32'h0);
		xf(1'h1, `ADDR_OFS, 32'hFFFF_0000);
		xf(1'h1, `ADDR_OFS + 8'h4, 32'hF000_0003);
		xf(1'h1, `ADDR_OFS + 8'h8, 32'h0000_000F);
		xf(1'h1, `ADDR_OFS + 8'hC, 32'hFF00_000C);
		rdc(`ADDR_OFS + 8'h8, 32'h0);
		rdc(`ADDR_OFS, 32'hF0FF_0000);
		xf(1'h1, `CTRL_OFS + 8'h8, 32'h5);
		xf(1'h1, `CTRL_OFS + 8'hC, 32'h6);
		xf(1'h1, `CTRL_OFS + 8'h4, 32'h2);
		xf(1'h1, `CTRL_OFS, 32'h3801);
		rdc(`CTRL_OFS, 32'h1);
		xf(1'h1, `CTRL_OFS, 32'h4004);
		xf(1'h1, `CTRL_OFS, 32'h4001);
		xf(1'h1, `CTRL_OFS, 32'hC004);
		rdc(`CTRL_OFS, 32'h4004);
		chk("lvd_en", 1'h1, lvd_enable_o);
		xf(1'h1, `DATA_OFS, 32'hA5A5_5A5A);
		idle(1);
		dev_reset_i = 1'h1;
		idle(1);
		dev_reset_i = 1'h0;
		idle(2);
		rdc(`CTRL_OFS, 32'h0004);
		chk("lvd_en", 1'h0, lvd_enable_o);
		chk("data", 32'hA5A5_5A5A, flash_data_o);
	endtask
	// f: tp, ap, fail, lvd, broken unlock, launch expected
	task automatic t_op(input logic [3:0] op, input logic [31:0] a,
		input logic [5:0] f);
		target_protected_i = f[5];
		array_protected_i = f[4];
		xf(1'h1, `CTRL_OFS, 32'h0);
		xf(1'h1, `CTRL_OFS, {28'h0, op});
		xf(1'h1, `ADDR_OFS, a);
		xf(1'h1, `CTRL_OFS, {16'h0, 2'h1, 10'h0, op});
		xf(1'h1, `KEY_OFS, `KEY_FIRST);
		xf(1'h1, `KEY_OFS, `KEY_SECOND);
		if (f[1]) xf(1'h0, `CTRL_OFS, 32'h0);
		xf(1'h1, `CTRL_OFS + 8'h8, 32'h8000);
		chk("start", f[0], flash_start_o);
		if (f[0]) chk("cmd", {op, a}, flash_cmd_o);
		idle(1);
		chk("start_end", 1'h0, flash_start_o);
		lvd_raw_i = f[2];
		idle(4);
		if (f[2]) rdc(`CTRL_OFS, {16'h0, 2'h3, ef, 2'h3, 7'h0, op});
		lvd_raw_i = 1'h0;
		idle(4);
		flash_fail_i = f[3];
		flash_done_i = f[0];
		idle(1);
		flash_done_i = 1'h0;
		if (f[0]) ef = f[3];
		if (f[0]) el = el | f[2];
		if (op == `OP_NONE) {ef, el} = 2'h0;
		rdc(`CTRL_OFS, {16'h0, 2'h1, ef, el, 8'h0, op});
	endtask
	initial begin
		repeat (4) @(negedge clk_i);
		reset_i = 1'h0;
		t_regs;
		t_op(`OP_WORD, 32'h100, 6'h01);
		t_op(`OP_ROW, 32'h200, 6'h09);
		t_op(`OP_PAGE, 32'h1000, 6'h05);
		t_op(`OP_NONE, 32'h0, 6'h00);
		t_op(`OP_ARRAY, 32'h300, 6'h21);
		t_op(`OP_ARRAY, 32'h0, 6'h10);
		t_op(`OP_WORD, 32'h40, 6'h20);
		t_op(4'h2, 32'h0, 6'h00);
		t_op(4'h6, 32'h0, 6'h00);
		t_op(4'hF, 32'h0, 6'h00);
		t_op(`OP_WORD, 32'h40, 6'h02);
		final_report;
	end
	// Roughly nine times the expected run
	initial begin
		#20000;
		n_mismatch++;
		final_report;
	end
endmodule
bind flash_prog_erase_control flash_prog_erase_control_props #(
	.ADDR_W(ADDR_W)
) u_flash_prog_erase_control_props (
	.clk_i         (clk_i),
	.reset_i       (reset_i),
	.bus_valid_i   (bus_valid_i),
	.bus_write_i   (bus_write_i),
	.bus_addr_i    (bus_addr_i),
	.bus_wdata_i   (bus_wdata_i),
	.bus_rdata_o   (bus_rdata_o),
	.flash_cmd_o   (flash_cmd_o),
	.flash_start_o (flash_start_o),
	.flash_data_o  (flash_data_o)
);
`default_nettype wire
